/* shared/pcs_params.svh */
// Offsets, field widths, reset values and address ranges of the program counter and stack unit.
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH
`define PCS_BANK_MASK_W 7
`define PCS_OFF_WIN0 7'h00
`define PCS_OFF_WIN1 7'h01
`define PCS_OFF_PC_LOW 7'h02
`define PCS_OFF_PTR0_LOW 7'h04
`define PCS_OFF_PTR0_HIGH 7'h05
`define PCS_OFF_PTR1_LOW 7'h06
`define PCS_OFF_PTR1_HIGH 7'h07
`define PCS_OFF_PC_LATCH 7'h0A
`define PCS_OFF_STATUS_BK 12'hFE4
`define PCS_OFF_WORK_BK 12'hFE5
`define PCS_OFF_BANK_BK 12'hFE6
`define PCS_OFF_LATCH_BK 12'hFE7
`define PCS_OFF_PTR0L_BK 12'hFE8
`define PCS_OFF_PTR0H_BK 12'hFE9
`define PCS_OFF_PTR1L_BK 12'hFEA
`define PCS_OFF_PTR1H_BK 12'hFEB
`define PCS_OFF_STK_PTR 12'hFED
`define PCS_OFF_TOS_LOW 12'hFEE
`define PCS_OFF_TOS_HIGH 12'hFEF
`define PCS_RST_STK_PTR 5'h1F
`define PCS_RST_WORK_BK 8'h00
`define PCS_STK_FULL_PTR 5'h0F
`define PCS_TRAD_LAST 16'h0FFF
`define PCS_LIN_FIRST 16'h2000
`define PCS_LIN_LAST 16'h29AF
`define PCS_LIN_BLOCK 13'h0050
`define PCS_GPR_BASE 12'h020
`define PCS_INT_VECTOR 15'h0004
`endif

/* shared/pcs_pkg.sv */
// Types shared by the program counter and stack unit.
`default_nettype none
package pcs_pkg;
	// Program-flow operation requested by the sequencer for this cycle.
	typedef enum logic [3:0] {
		PCS_OP_HOLD = 4'h0,
		PCS_OP_STEP = 4'h1,
		PCS_OP_CALL = 4'h2,
		PCS_OP_CALL_VIA_WORKING = 4'h3,
		PCS_OP_BRW = 4'h4,
		PCS_OP_BRA = 4'h5,
		PCS_OP_RET = 4'h6,
		PCS_OP_INTV = 4'h7
	} pcs_op_t;
	// Region that an indirect pointer falls into.
	typedef enum logic [1:0] {
		PCS_RG_TRAD = 2'h0,
		PCS_RG_LIN = 2'h1,
		PCS_RG_PROG = 2'h2,
		PCS_RG_NONE = 2'h3
	} pcs_region_t;
endpackage : pcs_pkg
`default_nettype wire

/* verilog/pcs_core.sv */
// Program counter, return stack and indirect address former of the core.
//
// What this block does
// - 15-bit counter, low byte visible, latch feeds top.
// - Any reset clears the program counter.
// - Low-byte write during a hold op also loads latch into top.
// - Call takes operand 10:0, latch bits 6:3.
// - Computed call takes working register and latch.
// - Working-register branch adds unsigned offset plus one.
// - Relative branch adds signed operand plus one.
// - Sixteen entry fifteen bit private return stack.
// - Calls and vectors push; returns pop.
// - Push and pop leave latch alone.
// - Stack wraps circularly when fault reset off.
// - Overflow and underflow flags always set.
// - Fault reset enabled: request device reset.
// - Five-bit pointer; top pair shows selected entry.
// - Push increments first; pop reads first.
// - Window access redirects to pointer pair address.
// - Window pointing at window reads zero, no write.
// - Pointer pairs form sixteen-bit, three-region address.
// - Low 4K maps straight to absolute addresses.
// - Linear region maps to 80-byte bank blocks.
// - Pointer top bit selects program memory read.
`include "pcs_params.svh"
`default_nettype none

module pcs_core #(
	parameter int STK_DEPTH = 16, // Return stack entries.
	parameter int PC_W = 15 // Program counter width.
) (
	input wire logic ref_clk, // Core clock, 10 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic clk_en, // Freezes all state while low.
	input wire logic [3:0] op, // Program-flow operation, pcs_pkg::pcs_op_t.
	input wire logic [10:0] op_operand, // Call target or relative branch offset (8:0).
	input wire logic [7:0] working_register, // Working register value.
	input wire logic [11:0] reg_addr, // Register file address.
	input wire logic reg_rd, // Register read strobe.
	input wire logic reg_wr, // Register write strobe.
	input wire logic [7:0] reg_wdata, // Register write data.
	input wire logic stack_fault_reset_enable, // Configuration strap.
	input wire logic flag_clear, // Clears both stack fault flags.
	output logic [7:0] reg_rdata, // Read data, one cycle after the strobe.
	output logic reg_hit, // Address belongs to this unit.
	output logic [PC_W-1:0] pc, // Program counter.
	output logic stack_overflow_flag, // Sticky overflow flag.
	output logic stack_underflow_flag, // Sticky underflow flag.
	output logic fault_reset_req, // One-cycle device reset request.
	output logic [11:0] eff_addr, // Data address after indirection.
	output logic [14:0] prog_addr, // Program memory address for window reads.
	output logic prog_rd, // Window read goes to program memory.
	output logic ind_zero, // Window read returns zero.
	output logic ext_wr // Write strobe to the data memory outside.
);
	// ------------------------------------------------------------
	// State.
	// ------------------------------------------------------------
	logic [PC_W-1:0] pc_r; // Program counter.
	logic [PC_W-1:0] pc_nxt; // Its next value.
	logic [6:0] pc_high_latch_r; // High-address latch.
	logic [7:0] ptr0_low_r; // File-select pointer 0, low byte.
	logic [7:0] ptr0_high_r; // File-select pointer 0, high byte.
	logic [7:0] ptr1_low_r; // File-select pointer 1, low byte.
	logic [7:0] ptr1_high_r; // File-select pointer 1, high byte.
	logic [7:0] bk_r [8]; // Backup registers at the shadow offsets.
	logic [4:0] return_stack_pointer_r; // Stack pointer.
	logic [4:0] sp_nxt; // Its next value.
	logic [PC_W-1:0] stk_r [STK_DEPTH]; // Return stack storage.
	logic ovf_r; // Overflow flag.
	logic unf_r; // Underflow flag.
	logic fault_r; // Reset request pulse.
	logic [7:0] rdata_r; // Registered read data.

	// ------------------------------------------------------------
	// Decode.
	// ------------------------------------------------------------
	wire pcs_pkg::pcs_op_t op_e = pcs_pkg::pcs_op_t'(op);
	wire [6:0] low7 = reg_addr[`PCS_BANK_MASK_W-1:0];
	wire core_hit = (low7 <= `PCS_OFF_PC_LATCH) && (low7 != 7'h03) && (low7 != 7'h08)
		&& (low7 != 7'h09);
	wire win_acc = (low7 == `PCS_OFF_WIN0) || (low7 == `PCS_OFF_WIN1);
	wire bk_hit = (reg_addr >= `PCS_OFF_STATUS_BK) && (reg_addr <= `PCS_OFF_PTR1H_BK);
	wire [2:0] bk_idx = reg_addr[2:0] - 3'h4;
	wire sp_hit = (reg_addr == `PCS_OFF_STK_PTR);
	wire stack_top_low_hit = (reg_addr == `PCS_OFF_TOS_LOW);
	wire stack_top_high_hit = (reg_addr == `PCS_OFF_TOS_HIGH);
	wire wr_ok = reg_wr && clk_en;
	wire wr_core = wr_ok && core_hit && !win_acc;
	wire [3:0] sp_idx = return_stack_pointer_r[3:0];
	wire [PC_W-1:0] stack_top_entry = stk_r[sp_idx]; // Entry under the pointer.
	wire [PC_W-1:0] pc_inc = pc_r + 15'h0001;

	// Push and pop requests, with their fault conditions.
	wire do_push = clk_en && ((op_e == pcs_pkg::PCS_OP_CALL) || (op_e == pcs_pkg::PCS_OP_CALL_VIA_WORKING)
		|| (op_e == pcs_pkg::PCS_OP_INTV));
	wire do_pop = clk_en && (op_e == pcs_pkg::PCS_OP_RET);
	wire push_ovf = do_push && (return_stack_pointer_r == `PCS_STK_FULL_PTR);
	wire pop_unf = do_pop && (return_stack_pointer_r == `PCS_RST_STK_PTR);
	// An interrupt returns to the instruction it displaced; calls return after themselves.
	wire [PC_W-1:0] push_val = (op_e == pcs_pkg::PCS_OP_INTV) ? pc_r : pc_inc;

	// ------------------------------------------------------------
	// Program counter next value.
	// ------------------------------------------------------------
	// Sign-extended relative offset and zero-extended working register.
	wire [PC_W-1:0] bra_off = {{6{op_operand[8]}}, op_operand[8:0]};
	wire [PC_W-1:0] brw_off = {7'h00, working_register};
	always_comb begin
		case (op_e)
			pcs_pkg::PCS_OP_STEP: pc_nxt = pc_inc;
			pcs_pkg::PCS_OP_CALL: pc_nxt = {pc_high_latch_r[6:3], op_operand};
			pcs_pkg::PCS_OP_CALL_VIA_WORKING: pc_nxt = {pc_high_latch_r, working_register};
			pcs_pkg::PCS_OP_BRW: pc_nxt = pc_inc + brw_off;
			pcs_pkg::PCS_OP_BRA: pc_nxt = pc_inc + bra_off;
			pcs_pkg::PCS_OP_RET: pc_nxt = stack_top_entry;
			pcs_pkg::PCS_OP_INTV: pc_nxt = `PCS_INT_VECTOR;
			pcs_pkg::PCS_OP_HOLD: begin
				// A low-byte write moves all fifteen bits together.
				if (wr_core && (low7 == `PCS_OFF_PC_LOW)) begin
					pc_nxt = {pc_high_latch_r, reg_wdata};
				end else begin
					pc_nxt = pc_r;
				end
			end
			default: pc_nxt = pc_r;
		endcase
	end

	// Counter clears on every reset; no other source feeds the reset value.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_r <= '0;
		end else if (clk_en) begin
			pc_r <= pc_nxt;
		end
	end

	// ------------------------------------------------------------
	// Core registers mirrored in every bank.
	// ------------------------------------------------------------
	// The latch only changes by a write; stack traffic never touches it.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_high_latch_r <= '0;
			ptr0_low_r <= '0;
			ptr0_high_r <= '0;
			ptr1_low_r <= '0;
			ptr1_high_r <= '0;
		end else if (wr_core) begin
			case (low7)
				`PCS_OFF_PC_LATCH: pc_high_latch_r <= reg_wdata[6:0];
				`PCS_OFF_PTR0_LOW: ptr0_low_r <= reg_wdata;
				`PCS_OFF_PTR0_HIGH: ptr0_high_r <= reg_wdata;
				`PCS_OFF_PTR1_LOW: ptr1_low_r <= reg_wdata;
				`PCS_OFF_PTR1_HIGH: ptr1_high_r <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// Backup registers are plain storage filled only by software writes at their shadow offsets.
	generate
		for (genvar g = 0; g < 8; g++) begin : g_bk
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					bk_r[g] <= `PCS_RST_WORK_BK;
				end else if (wr_ok && bk_hit && (bk_idx == 3'(g))) begin
					bk_r[g] <= reg_wdata;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Return stack.
	// ------------------------------------------------------------
	// Pointer is five bits so one past full and one below empty are visible.
	always_comb begin
		if (do_push) begin
			sp_nxt = return_stack_pointer_r + 5'h01;
		end else if (do_pop) begin
			sp_nxt = return_stack_pointer_r - 5'h01;
		end else if (wr_ok && sp_hit) begin
			sp_nxt = reg_wdata[4:0];
		end else begin
			sp_nxt = return_stack_pointer_r;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			return_stack_pointer_r <= `PCS_RST_STK_PTR;
		end else if (clk_en) begin
			return_stack_pointer_r <= sp_nxt;
		end
	end

	// Push writes the entry the incremented pointer selects, so entry 16 wraps onto entry 0.
	// Software writes to the top pair lose to a push in the same cycle.
	generate
		for (genvar e = 0; e < STK_DEPTH; e++) begin : g_stk
			wire push_here = do_push && (sp_nxt[3:0] == 4'(e));
			wire sw_here = wr_ok && !do_push && (sp_idx == 4'(e));
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					stk_r[e] <= '0;
				end else if (push_here) begin
					stk_r[e] <= push_val;
				end else if (sw_here && stack_top_low_hit) begin
					stk_r[e] <= {stk_r[e][14:8], reg_wdata};
				end else if (sw_here && stack_top_high_hit) begin
					stk_r[e] <= {reg_wdata[6:0], stk_r[e][7:0]};
				end
			end
		end
	endgenerate

	// Fault flags are sticky; a fault in the clearing cycle keeps the flag set.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ovf_r <= 1'b0;
			unf_r <= 1'b0;
			fault_r <= 1'b0;
		end else if (clk_en) begin
			ovf_r <= push_ovf || (ovf_r && !flag_clear);
			unf_r <= pop_unf || (unf_r && !flag_clear);
			fault_r <= stack_fault_reset_enable && (push_ovf || pop_unf);
		end
	end

	// ------------------------------------------------------------
	// Indirect address forming.
	// ------------------------------------------------------------
	wire [15:0] fa = (low7 == `PCS_OFF_WIN1) ? {ptr1_high_r, ptr1_low_r}
		: {ptr0_high_r, ptr0_low_r};
	wire [12:0] lin = 13'(fa - `PCS_LIN_FIRST);
	wire [4:0] lin_bank = 5'(lin / `PCS_LIN_BLOCK);
	wire [6:0] lin_off = 7'(lin % `PCS_LIN_BLOCK);
	wire [11:0] lin_abs = {lin_bank, 7'h00} + `PCS_GPR_BASE + {5'h00, lin_off};
	wire pcs_pkg::pcs_region_t region = fa[15] ? pcs_pkg::PCS_RG_PROG
		: (fa <= `PCS_TRAD_LAST) ? pcs_pkg::PCS_RG_TRAD
		: ((fa >= `PCS_LIN_FIRST) && (fa <= `PCS_LIN_LAST)) ? pcs_pkg::PCS_RG_LIN
		: pcs_pkg::PCS_RG_NONE;
	// A pointer aimed back at a window would loop, so it reads as zero instead.
	wire self_ref = (region == pcs_pkg::PCS_RG_TRAD) && (fa[6:0] <= `PCS_OFF_WIN1);
	wire ind_blk = win_acc && (self_ref || (region == pcs_pkg::PCS_RG_NONE));
	assign eff_addr = !win_acc ? reg_addr
		: (region == pcs_pkg::PCS_RG_LIN) ? lin_abs : fa[11:0];
	assign prog_addr = fa[14:0];
	assign prog_rd = win_acc && reg_rd && (region == pcs_pkg::PCS_RG_PROG);
	assign ind_zero = ind_blk;
	// Program memory cannot be written through the window.
	assign ext_wr = wr_ok && !reg_hit && !ind_blk && !(win_acc && fa[15]);

	// ------------------------------------------------------------
	// Read path.
	// ------------------------------------------------------------
	assign reg_hit = (core_hit && !win_acc) || bk_hit || sp_hit || stack_top_low_hit || stack_top_high_hit;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= '0;
		end else if (clk_en && reg_rd) begin
			if (sp_hit) begin
				rdata_r <= {3'h0, return_stack_pointer_r};
			end else if (stack_top_low_hit) begin
				rdata_r <= stack_top_entry[7:0];
			end else if (stack_top_high_hit) begin
				rdata_r <= {1'b0, stack_top_entry[14:8]};
			end else if (bk_hit) begin
				rdata_r <= bk_r[bk_idx];
			end else if (win_acc || !core_hit) begin
				rdata_r <= 8'h00; // Outside data or any window access.
			end else begin
				case (low7)
					`PCS_OFF_PC_LOW: rdata_r <= pc_r[7:0];
					`PCS_OFF_PC_LATCH: rdata_r <= {1'b0, pc_high_latch_r};
					`PCS_OFF_PTR0_LOW: rdata_r <= ptr0_low_r;
					`PCS_OFF_PTR0_HIGH: rdata_r <= ptr0_high_r;
					`PCS_OFF_PTR1_LOW: rdata_r <= ptr1_low_r;
					`PCS_OFF_PTR1_HIGH: rdata_r <= ptr1_high_r;
					default: rdata_r <= 8'h00;
				endcase
			end
		end
	end

	assign reg_rdata = rdata_r;
	assign pc = pc_r;
	assign stack_overflow_flag = ovf_r;
	assign stack_underflow_flag = unf_r;
	assign fault_reset_req = fault_r;

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// Counter loads for step, both calls, both branches and the low-byte write, plus the frozen-enable case.
	a_step_inc: assert property (
		clk_en && op_e == pcs_pkg::PCS_OP_STEP
		|=> pc_r == 15'($past(pc_r) + 15'h0001)) else $error("step");
	a_state_frozen: assert property (
		!clk_en |=> $stable(pc_r) && $stable(return_stack_pointer_r))
		else $error("frozen state moved");
	a_pc_low_write: assert property (
		wr_core && low7 == `PCS_OFF_PC_LOW && op_e == pcs_pkg::PCS_OP_HOLD
		|=> pc_r == {$past(pc_high_latch_r), $past(reg_wdata)}) else $error("pc low write");
	a_call_target: assert property (
		clk_en && op_e == pcs_pkg::PCS_OP_CALL
		|=> pc_r == {$past(pc_high_latch_r[6:3]), $past(op_operand)}) else $error("call");
	a_call_via_working_target: assert property (
		clk_en && op_e == pcs_pkg::PCS_OP_CALL_VIA_WORKING
		|=> pc_r == {$past(pc_high_latch_r), $past(working_register)}) else $error("call_via_working");
	a_brw_target: assert property (
		clk_en && op_e == pcs_pkg::PCS_OP_BRW
		|=> pc_r == 15'($past(pc_r) + 15'h0001 + {7'h00, $past(working_register)}))
		else $error("brw");
	a_bra_target: assert property (
		clk_en && op_e == pcs_pkg::PCS_OP_BRA
		|=> pc_r == 15'($past(pc_r) + 15'h0001
		+ {{6{$past(op_operand[8])}}, $past(op_operand[8:0])})) else $error("bra");
	// Stack traffic: the pushed entry must be the one the pointer then selects.
	a_push_then_pop: assert property (
		do_push && op_e == pcs_pkg::PCS_OP_CALL ##1 do_pop
		|=> pc_r == 15'($past(pc_r, 2) + 15'h0001)) else $error("call return");
	a_push_entry: assert property (
		do_push |=> stack_top_entry == $past(push_val)) else $error("push entry");
	a_pop_pointer: assert property (
		do_pop |=> return_stack_pointer_r == 5'($past(return_stack_pointer_r) - 5'h01))
		else $error("pop pointer");
	a_pointer_write: assert property (
		wr_ok && sp_hit && !do_push && !do_pop
		|=> return_stack_pointer_r == $past(reg_wdata[4:0])) else $error("pointer write");
	a_latch_kept: assert property (
		(do_push || do_pop) && !wr_core |=> $stable(pc_high_latch_r)) else $error("latch moved");
	a_ovf_flag: assert property (
		push_ovf |=> ovf_r && return_stack_pointer_r == 5'h10
		&& fault_r == $past(stack_fault_reset_enable)) else $error("overflow");
	a_unf_flag: assert property (
		pop_unf |=> unf_r && return_stack_pointer_r == 5'h1E
		&& fault_r == $past(stack_fault_reset_enable)) else $error("underflow");
	// Indirection: a window never hands back data of its own.
	a_window_self: assert property (
		win_acc && self_ref |-> ind_zero && !ext_wr) else $error("window self access");
	a_window_read_zero: assert property (
		clk_en && reg_rd && win_acc |=> reg_rdata == 8'h00) else $error("window read");
endmodule : pcs_core
`default_nettype wire

/* test/pcs_seq_model.sv */
// Sequencer model that feeds one program-flow operation at a time to the unit.
`default_nettype none
module pcs_seq_model (
	input wire logic ref_clk, // Core clock.
	output logic [3:0] op, // Operation for the unit.
	output logic [10:0] op_operand, // Call target or branch offset.
	output logic [7:0] working_register // Working register value.
);
	timeunit 1ns;
	timeprecision 1ns;
	// -------------------------------------------------------------
	// Idle state: hold, so the counter stays put between requests.
	// -------------------------------------------------------------
	initial begin
		op = pcs_pkg::PCS_OP_HOLD;
		op_operand = 11'h000;
		working_register = 8'h00;
	end
	// Drives one operation for exactly one edge, then goes back to hold.
	// Ops never overlap a pointer rewrite, so no push interleaves with it.
	task automatic issue(input pcs_pkg::pcs_op_t kind, input logic [10:0] arg,
		input logic [7:0] w);
		@(posedge ref_clk);
		#10;
		op = kind;
		op_operand = arg;
		working_register = w;
		@(posedge ref_clk);
		#10;
		op = pcs_pkg::PCS_OP_HOLD;
	endtask : issue
	// Drives a call and its return on two neighbouring edges, with no hold between.
	task automatic call_return(input logic [10:0] target);
		@(posedge ref_clk);
		#10;
		op = pcs_pkg::PCS_OP_CALL;
		op_operand = target;
		@(posedge ref_clk);
		#10;
		op = pcs_pkg::PCS_OP_RET;
		@(posedge ref_clk);
		#10;
		op = pcs_pkg::PCS_OP_HOLD;
	endtask : call_return
endmodule : pcs_seq_model
`default_nettype wire

/* test/program_counter_and_call_stack_bench.sv */
// Self-checking bench of the program counter, return stack and indirection unit.
`include "pcs_params.svh"
`default_nettype none
module program_counter_and_call_stack_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0; // Core clock.
	logic rst_n = 1'b0; // Reset, active low.
	logic clk_en = 1'b1; // Clock enable.
	logic [11:0] reg_addr = 12'h000; // Register address.
	logic reg_rd = 1'b0; // Read strobe.
	logic reg_wr = 1'b0; // Write strobe.
	logic [7:0] reg_wdata = 8'h00; // Write data.
	logic sfre = 1'b0; // Stack fault reset enable.
	logic flag_clear = 1'b0; // Fault flag clear.
	logic [3:0] op; // From the sequencer model.
	logic [10:0] op_operand; // From the sequencer model.
	logic [7:0] working_register; // From the sequencer model.
	logic [7:0] reg_rdata; // Read data.
	logic [14:0] pc; // Program counter.
	logic ovf; // Overflow flag.
	logic unf; // Underflow flag.
	logic frr; // Device reset request.
	logic [11:0] eff_addr; // Indirected address.
	logic [14:0] prog_addr; // Program memory address.
	logic prog_rd; // Program memory read.
	logic ind_zero; // Read-zero, write-suppress.
	logic ext_wr; // Outside write strobe.
	logic hit; // Address claimed by the unit.
	int num_errors = 0; // Mismatches.
	int checks_done = 0; // Comparisons.
	int frr_seen = 0; // Reset requests seen.

	always #50 ref_clk = ~ref_clk;

	pcs_seq_model pcs_seq_model_inst (.ref_clk(ref_clk), .op(op), .op_operand(op_operand),
		.working_register(working_register));
	pcs_core pcs_core_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .op(op),
		.op_operand(op_operand), .working_register(working_register), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.stack_fault_reset_enable(sfre), .flag_clear(flag_clear), .reg_rdata(reg_rdata),
		.reg_hit(hit), .pc(pc), .stack_overflow_flag(ovf), .stack_underflow_flag(unf),
		.fault_reset_req(frr), .eff_addr(eff_addr), .prog_addr(prog_addr),
		.prog_rd(prog_rd), .ind_zero(ind_zero), .ext_wr(ext_wr));

	// A reset request is a one-cycle pulse, so it is counted at every edge.
	always @(posedge ref_clk) if (frr === 1'b1) frr_seen++;

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	task automatic do_reset(input logic en);
		rst_n = 1'b0;
		sfre = en;
		repeat (4) @(posedge ref_clk);
		#10;
		rst_n = 1'b1;
		frr_seen = 0;
	endtask : do_reset
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#10;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#10;
		reg_wr = 1'b0;
	endtask : wr
	// Reads one register; data stands from the edge that takes the strobe.
	task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		#10;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#10;
		reg_rd = 1'b0;
		check(reg_rdata, exp);
	endtask : rdchk
	// Presents a window access and judges the combinational steering mid-cycle.
	task automatic poke(input logic [11:0] a, input logic w, input logic r,
		input logic e_zero, input logic e_ext, input logic e_prog);
		@(posedge ref_clk);
		#10;
		reg_addr = a;
		reg_wr = w;
		reg_rd = r;
		#20;
		check(ind_zero, e_zero);
		check(ext_wr, e_ext);
		check(prog_rd, e_prog);
		check(hit, 16'h0000);
		@(posedge ref_clk);
		#10;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	endtask : poke

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_and_pcl();
		check(pc, 16'h0000);
		rdchk(`PCS_OFF_STK_PTR, 8'h1F);
		check(hit, 16'h0001);
		rdchk(`PCS_OFF_WORK_BK, `PCS_RST_WORK_BK);
		rdchk(12'hFEC, 8'h00);
		wr(`PCS_OFF_PC_LATCH, 8'h12);
		wr(`PCS_OFF_PC_LOW, 8'h34);
		check(pc, 16'h1234);
		rdchk(`PCS_OFF_PC_LOW, 8'h34);
		// A frozen clock enable must hold the counter still.
		clk_en = 1'b0;
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_STEP, 11'h000, 8'h00);
		check(pc, 16'h1234);
		clk_en = 1'b1;
	endtask : t_reset_and_pcl
	task automatic t_calls_and_branches();
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_CALL, 11'h100, 8'h00);
		check(pc, 16'h1100);
		rdchk(`PCS_OFF_STK_PTR, 8'h00);
		rdchk(`PCS_OFF_TOS_LOW, 8'h35);
		rdchk(`PCS_OFF_TOS_HIGH, 8'h12);
		rdchk(`PCS_OFF_PC_LATCH, 8'h12);
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_CALL_VIA_WORKING, 11'h000, 8'h56);
		check(pc, 16'h1256);
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_RET, 11'h000, 8'h00);
		check(pc, 16'h1101);
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_RET, 11'h000, 8'h00);
		check(pc, 16'h1235);
		rdchk(`PCS_OFF_STK_PTR, 8'h1F);
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_BRW, 11'h000, 8'hFF);
		check(pc, 16'h1335);
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_BRA, 11'h1FE, 8'h00);
		check(pc, 16'h1334);
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_BRA, 11'h0FF, 8'h00);
		check(pc, 16'h1434);
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_INTV, 11'h000, 8'h00);
		check(pc, {1'b0, `PCS_INT_VECTOR});
		rdchk(`PCS_OFF_TOS_LOW, 8'h34);
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_RET, 11'h000, 8'h00);
		check(pc, 16'h1434);
		// A return on the edge right after a call must undo it at once.
		pcs_seq_model_inst.call_return(11'h200);
		check(pc, 16'h1435);
		check({ovf, unf}, 16'h0000);
	endtask : t_calls_and_branches
	// Seventeen calls with the fault reset off: entry zero is overwritten.
	task automatic t_overflow();
		wr(`PCS_OFF_PC_LATCH, 8'h00);
		wr(`PCS_OFF_PC_LOW, 8'h00);
		for (int k = 1; k <= 16; k++) begin
			pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_CALL, k[10:0], 8'h00);
		end
		check(ovf, 16'h0000);
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_CALL, 11'h011, 8'h00);
		check(ovf, 16'h0001);
		rdchk(`PCS_OFF_STK_PTR, 8'h10);
		wr(`PCS_OFF_STK_PTR, 8'h00);
		rdchk(`PCS_OFF_TOS_LOW, 8'h11);
		wr(`PCS_OFF_STK_PTR, 8'h01);
		rdchk(`PCS_OFF_TOS_LOW, 8'h02);
		check(frr_seen[15:0], 16'h0000);
		@(posedge ref_clk);
		#10;
		flag_clear = 1'b1;
		@(posedge ref_clk);
		#10;
		flag_clear = 1'b0;
		check(ovf, 16'h0000);
	endtask : t_overflow
	// Underflow with the fault reset on, then a software-built return address.
	task automatic t_underflow_and_tos();
		do_reset(1'b1);
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_RET, 11'h000, 8'h00);
		#20;
		check(unf, 16'h0001);
		check(frr, 16'h0001);
		wr(`PCS_OFF_STK_PTR, 8'h03);
		check(frr_seen[15:0], 16'h0001);
		wr(`PCS_OFF_TOS_LOW, 8'hAB);
		wr(`PCS_OFF_TOS_HIGH, 8'h85);
		rdchk(`PCS_OFF_TOS_HIGH, 8'h05);
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_RET, 11'h000, 8'h00);
		check(pc, 16'h05AB);
		rdchk(`PCS_OFF_STK_PTR, 8'h02);
		pcs_seq_model_inst.issue(pcs_pkg::PCS_OP_STEP, 11'h000, 8'h00);
		check(pc, 16'h05AC);
	endtask : t_underflow_and_tos
	task automatic t_indirect();
		wr(`PCS_OFF_PTR0_HIGH, 8'h00);
		wr(`PCS_OFF_PTR0_LOW, 8'h23);
		poke(`PCS_OFF_WIN0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		check(eff_addr, 16'h0023);
		wr(`PCS_OFF_PTR1_HIGH, 8'h00);
		wr(`PCS_OFF_PTR1_LOW, 8'h81);
		poke(`PCS_OFF_WIN1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		wr(`PCS_OFF_PTR0_HIGH, 8'h20);
		wr(`PCS_OFF_PTR0_LOW, 8'h50);
		poke(`PCS_OFF_WIN0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		check(eff_addr, 16'h00A0);
		wr(`PCS_OFF_PTR0_HIGH, 8'h29);
		wr(`PCS_OFF_PTR0_LOW, 8'hB0);
		poke(`PCS_OFF_WIN0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		wr(`PCS_OFF_PTR0_HIGH, 8'h80);
		wr(`PCS_OFF_PTR0_LOW, 8'h10);
		poke(`PCS_OFF_WIN0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		check(prog_addr, 16'h0010);
	endtask : t_indirect

	// ---------------------------------------------------------------
	// Main sequence and hang guard
	// ---------------------------------------------------------------
	initial begin
		do_reset(1'b0);
		t_reset_and_pcl();
		t_calls_and_branches();
		t_overflow();
		t_underflow_and_tos();
		t_indirect();
		summarize();
	end
	// The whole run needs far fewer cycles; running out means a hang.
	initial begin
		repeat (5000) @(posedge ref_clk);
		num_errors++;
		summarize();
	end
endmodule : program_counter_and_call_stack_bench
`default_nettype wire
